//--- hw/soft_reset_request_regs.sv
// Two masked-write software reset request registers with reset outputs
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

module soft_reset_request_regs
	import soft_reset_pkg::*;
(
	input wire logic ref_clk_in,
	input wire logic reset_n_in,
	input wire logic [ADDR_W-1:0] addr_in,
	input wire logic [31:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [31:0] rdata_out,
	output logic disp_apb_reset_request_out,
	output logic disp_axi_reset_request_out,
	output logic ts_hsadc_reset_request_out,
	output logic ts_core_reset_request_out,
	output logic ts_ahb_reset_request_out,
	output logic ts_axi_reset_request_out,
	output logic dma_reset_request_out,
	output logic pwm_apb_reset_request_out,
	output logic pwm_core_reset_request_out,
	output logic fuse_nonsecure_apb_reset_request_out,
	output logic fuse_secure_apb_reset_request_out,
	output logic [3:0] i2c_apb_reset_request_out,
	output logic usb3_regfile_reset_request_out,
	output logic [5:0] timer_reset_request_out,
	output logic timer_block_apb_reset_request_out,
	output logic usb_regfile_reset_request_out,
	output logic gen_regfile_reset_request_out,
	output logic sec_regfile_reset_request_out,
	output logic crypto_reset_request_out,
	output logic tadc_apb_reset_request_out,
	output logic tadc_core_reset_request_out,
	output logic spi_first_reset_request_out,
	output logic smart_card_reset_request_out
);

	////////////////////////////////////////////////////////////////////////
	// Masked write: each upper bit enables the bit sixteen below it, except reserved bit 15 of register A
	function automatic logic [REQ_W-1:0] masked_write(
		input logic [REQ_W-1:0] old_val,
		input logic [31:0] data,
		input logic [REQ_W-1:0] impl
	);
		logic [REQ_W-1:0] en;
		en = data[31:MASK_LSB] & impl;
		masked_write = (old_val & ~en) | (data[REQ_W-1:0] & en);
	endfunction

	bus_req_t bus;
	state_t state;
	state_t next_state;

	assign bus = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};

	////////////////////////////////////////////////////////////////////////
	// Next state: writes, read data for the following cycle
	always_comb begin
		next_state = state;
		next_state.rdata = 32'h0000_0000;
		if (bus.wr && bus.addr == REQ_A_OFFSET) begin
			next_state.req_a = masked_write(state.req_a, bus.wdata, REQ_A_IMPL);
		end
		if (bus.wr && bus.addr == REQ_B_OFFSET) begin
			next_state.req_b = masked_write(state.req_b, bus.wdata, REQ_B_IMPL);
		end
		// Mask half always reads zero; unmapped addresses read zero
		if (bus.rd && bus.addr == REQ_A_OFFSET) begin
			next_state.rdata = {16'h0000, state.req_a};
		end
		if (bus.rd && bus.addr == REQ_B_OFFSET) begin
			next_state.rdata = {16'h0000, state.req_b};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// State register; requests only change by software writes or reset
	always_ff @(posedge ref_clk_in) begin
		if (!reset_n_in) begin
			state <= '{req_a: REQ_RESET, req_b: REQ_RESET,
				rdata: 32'h0000_0000};
		end else begin
			state <= next_state;
		end
	end

	assign rdata_out = state.rdata;

	////////////////////////////////////////////////////////////////////////
	// Register A reset request outputs, level while bit is one
	assign disp_apb_reset_request_out = state.req_a[A_DISP_APB];
	assign disp_axi_reset_request_out = state.req_a[A_DISP_AXI];
	assign ts_hsadc_reset_request_out = state.req_a[A_TS_HSADC];
	assign ts_core_reset_request_out = state.req_a[A_TS_CORE];
	assign ts_ahb_reset_request_out = state.req_a[A_TS_AHB];
	assign ts_axi_reset_request_out = state.req_a[A_TS_AXI];
	assign dma_reset_request_out = state.req_a[A_DMA];
	assign pwm_apb_reset_request_out = state.req_a[A_PWM_APB];
	assign pwm_core_reset_request_out = state.req_a[A_PWM_CORE];
	assign fuse_nonsecure_apb_reset_request_out =
		state.req_a[A_FUSE_NS];
	assign fuse_secure_apb_reset_request_out =
		state.req_a[A_FUSE_SE];
	// Index n drives I2C controller n
	assign i2c_apb_reset_request_out =
		state.req_a[A_I2C_LSB+:4];

	////////////////////////////////////////////////////////////////////////
	// Register B reset request outputs
	assign usb3_regfile_reset_request_out = state.req_b[B_USB3_RF];
	// Index n drives timer n
	assign timer_reset_request_out = state.req_b[B_TIMER_LSB+:6];
	assign timer_block_apb_reset_request_out =
		state.req_b[B_TIMER_APB];
	assign usb_regfile_reset_request_out = state.req_b[B_USB_RF];
	assign gen_regfile_reset_request_out = state.req_b[B_GEN_RF];
	assign sec_regfile_reset_request_out = state.req_b[B_SEC_RF];
	assign crypto_reset_request_out = state.req_b[B_CRYPTO];
	assign tadc_apb_reset_request_out = state.req_b[B_TADC_APB];
	assign tadc_core_reset_request_out = state.req_b[B_TADC_CORE];
	assign spi_first_reset_request_out = state.req_b[B_SPI];
	assign smart_card_reset_request_out = state.req_b[B_SCARD];

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!reset_n_in);

	AST_MASKED_SET_A: assert property (
		bus.wr && bus.addr == REQ_A_OFFSET && bus.wdata[16+A_DMA]
		|=> dma_reset_request_out == $past(bus.wdata[A_DMA]))
		else $error("masked write to register A not applied");
	AST_UNMASKED_HOLD_B: assert property (
		bus.wr && bus.addr == REQ_B_OFFSET && !bus.wdata[16+B_CRYPTO]
		|=> $stable(crypto_reset_request_out))
		else $error("unmasked bit of register B changed");
	AST_READ_A: assert property (
		bus.rd && bus.addr == REQ_A_OFFSET && !bus.wr
		|=> rdata_out == {16'h0000, $past(state.req_a)})
		else $error("register A read back wrong");
	AST_READ_B_MASK_ZERO: assert property (
		bus.rd && bus.addr == REQ_B_OFFSET |=> rdata_out[31:16] == 16'h0000)
		else $error("mask half of register B not zero");
	AST_RESERVED_ZERO: assert property (
		!state.req_a[15])
		else $error("reserved bit of register A set");
	AST_NO_SELF_CLEAR: assert property (
		!(bus.wr && bus.addr == REQ_B_OFFSET) ##1 1
		|-> state.req_b == $past(state.req_b))
		else $error("register B changed without a write");
	AST_TIMER_MAP: assert property (
		bus.wr && bus.addr == REQ_B_OFFSET && bus.wdata[31:16] == 16'hFFFF
		|=> timer_reset_request_out == $past(bus.wdata[14:9]))
		else $error("timer reset map wrong");
	AST_I2C_MAP: assert property (
		bus.wr && bus.addr == REQ_A_OFFSET && bus.wdata[19:16] == 4'hF
		|=> i2c_apb_reset_request_out == $past(bus.wdata[3:0]))
		else $error("i2c reset map wrong");
	AST_UNMAPPED_ZERO: assert property (
		bus.rd && bus.addr != REQ_A_OFFSET && bus.addr != REQ_B_OFFSET
		|=> rdata_out == 32'h0000_0000)
		else $error("unmapped read not zero");

	////////////////////////////////////////////////////////////////////////
	// Reset and read-back checks
	// Reset is not a disable here: the clear itself is what is checked
	AST_RESET_CLEARS: assert property (disable iff (1'b0)
		!reset_n_in |=> state == '0)
		else $error("reset did not clear the block");
	AST_READ_B: assert property (
		bus.rd && bus.addr == REQ_B_OFFSET
		|=> rdata_out == {16'h0000, $past(state.req_b)})
		else $error("register B read back wrong");
	// Read data stand one cycle only, so stale data never linger
	AST_RDATA_ONE_CYCLE: assert property (
		!bus.rd |=> rdata_out == 32'h0000_0000)
		else $error("read data outside a read cycle");
	AST_RESERVED_READ: assert property (
		bus.rd && bus.addr == REQ_A_OFFSET |=> !rdata_out[15])
		else $error("reserved bit of register A read as one");

	////////////////////////////////////////////////////////////////////////
	// Decode checks: a write to A leaves B, an unmapped write leaves both; full-mask write to B applied
	AST_DECODE_A: assert property (
		bus.wr && bus.addr == REQ_A_OFFSET |=> $stable(state.req_b))
		else $error("write to register A changed register B");
	AST_MASKED_SET_B: assert property (
		bus.wr && bus.addr == REQ_B_OFFSET
		&& bus.wdata[31:MASK_LSB] == 16'hFFFF
		|=> state.req_b == $past(bus.wdata[15:0]))
		else $error("full mask write to register B not applied");
	AST_UNMAPPED_WRITE: assert property (
		bus.wr && bus.addr != REQ_A_OFFSET && bus.addr != REQ_B_OFFSET
		|=> $stable(state.req_a) && $stable(state.req_b))
		else $error("unmapped write changed a register");

	////////////////////////////////////////////////////////////////////////
	// Register A output map, checked with the field's mask bits all set; DMA hold checked with its mask bit clear
	AST_DISP_MAP: assert property (
		bus.wr && bus.addr == REQ_A_OFFSET
		&& (&bus.wdata[MASK_LSB+A_DISP_AXI+:2])
		|=> {disp_apb_reset_request_out, disp_axi_reset_request_out}
			== $past(bus.wdata[A_DISP_AXI+:2]))
		else $error("display reset map wrong");
	AST_TS_MAP: assert property (
		bus.wr && bus.addr == REQ_A_OFFSET
		&& (&bus.wdata[MASK_LSB+A_TS_AXI+:4])
		|=> {ts_hsadc_reset_request_out, ts_core_reset_request_out,
			ts_ahb_reset_request_out, ts_axi_reset_request_out}
			== $past(bus.wdata[A_TS_AXI+:4]))
		else $error("stream unit reset map wrong");
	AST_DMA_HOLD: assert property (
		bus.wr && bus.addr == REQ_A_OFFSET && !bus.wdata[MASK_LSB+A_DMA]
		|=> $stable(dma_reset_request_out))
		else $error("unmasked DMA request changed");
	AST_PWM_MAP: assert property (
		bus.wr && bus.addr == REQ_A_OFFSET
		&& (&bus.wdata[MASK_LSB+A_PWM_CORE+:2])
		|=> {pwm_apb_reset_request_out, pwm_core_reset_request_out}
			== $past(bus.wdata[A_PWM_CORE+:2]))
		else $error("PWM reset map wrong");
	AST_FUSE_MAP: assert property (
		bus.wr && bus.addr == REQ_A_OFFSET
		&& (&bus.wdata[MASK_LSB+A_FUSE_SE+:2])
		|=> {fuse_nonsecure_apb_reset_request_out,
			fuse_secure_apb_reset_request_out}
			== $past(bus.wdata[A_FUSE_SE+:2]))
		else $error("fuse reset map wrong");

	////////////////////////////////////////////////////////////////////////
	// Register B output map
	AST_USB3_MAP: assert property (
		bus.wr && bus.addr == REQ_B_OFFSET && bus.wdata[MASK_LSB+B_USB3_RF]
		|=> usb3_regfile_reset_request_out == $past(bus.wdata[B_USB3_RF]))
		else $error("USB3 register file reset map wrong");
	AST_TIMER_APB_MAP: assert property (
		bus.wr && bus.addr == REQ_B_OFFSET
		&& bus.wdata[MASK_LSB+B_TIMER_APB]
		|=> timer_block_apb_reset_request_out
			== $past(bus.wdata[B_TIMER_APB]))
		else $error("timer block reset map wrong");
	AST_REGFILE_MAP: assert property (
		bus.wr && bus.addr == REQ_B_OFFSET
		&& (&bus.wdata[MASK_LSB+B_SEC_RF+:3])
		|=> {usb_regfile_reset_request_out, gen_regfile_reset_request_out,
			sec_regfile_reset_request_out}
			== $past(bus.wdata[B_SEC_RF+:3]))
		else $error("register file reset map wrong");
	AST_CRYPTO_MAP: assert property (
		bus.wr && bus.addr == REQ_B_OFFSET && bus.wdata[MASK_LSB+B_CRYPTO]
		|=> crypto_reset_request_out == $past(bus.wdata[B_CRYPTO]))
		else $error("crypto reset map wrong");
	AST_TADC_MAP: assert property (
		bus.wr && bus.addr == REQ_B_OFFSET
		&& (&bus.wdata[MASK_LSB+B_TADC_CORE+:2])
		|=> {tadc_apb_reset_request_out, tadc_core_reset_request_out}
			== $past(bus.wdata[B_TADC_CORE+:2]))
		else $error("temperature ADC reset map wrong");
	AST_SPI_CARD_MAP: assert property (
		bus.wr && bus.addr == REQ_B_OFFSET
		&& (&bus.wdata[MASK_LSB+B_SCARD+:2])
		|=> {spi_first_reset_request_out, smart_card_reset_request_out}
			== $past(bus.wdata[B_SCARD+:2]))
		else $error("SPI and smart card reset map wrong");

	////////////////////////////////////////////////////////////////////////
	// Coverage of the main scenarios
	COV_RESERVED_WRITE: cover property (
		bus.wr && bus.addr == REQ_A_OFFSET && bus.wdata[31] && bus.wdata[15]);
	COV_UNMAPPED_READ: cover property (
		bus.rd && bus.addr != REQ_A_OFFSET && bus.addr != REQ_B_OFFSET);
	COV_SET_RELEASE: cover property (
		dma_reset_request_out ##[1:20] !dma_reset_request_out);
	COV_MASKED_OFF: cover property (
		bus.wr && bus.addr == REQ_A_OFFSET && bus.wdata[31:16] == 16'h0000
		&& bus.wdata[15:0] != 16'h0000);
	COV_BACK_TO_BACK: cover property (
		bus.wr && bus.addr == REQ_B_OFFSET ##1 bus.rd && bus.addr == REQ_B_OFFSET);

endmodule

`default_nettype wire

//--- pkg/soft_reset_pkg.sv
// Package: register map, field layout and types of the soft reset requests
package soft_reset_pkg;

	localparam int ADDR_W = 12;
	localparam logic [11:0] REQ_A_OFFSET = 12'h30C;
	localparam logic [11:0] REQ_B_OFFSET = 12'h310;
	localparam int MASK_LSB = 16;
	localparam int REQ_W = 16;
	localparam logic [15:0] REQ_RESET = 16'h0000;
	// Bit 15 of register A is reserved
	localparam logic [15:0] REQ_A_IMPL = 16'h7FFF;
	localparam logic [15:0] REQ_B_IMPL = 16'hFFFF;

	// Register A bit positions
	localparam int A_DISP_APB = 14;
	localparam int A_DISP_AXI = 13;
	localparam int A_TS_HSADC = 12;
	localparam int A_TS_CORE = 11;
	localparam int A_TS_AHB = 10;
	localparam int A_TS_AXI = 9;
	localparam int A_DMA = 8;
	localparam int A_PWM_APB = 7;
	localparam int A_PWM_CORE = 6;
	localparam int A_FUSE_NS = 5;
	localparam int A_FUSE_SE = 4;
	localparam int A_I2C_LSB = 0;
	// Register B bit positions
	localparam int B_USB3_RF = 15;
	localparam int B_TIMER_LSB = 9;
	localparam int B_TIMER_APB = 8;
	localparam int B_USB_RF = 7;
	localparam int B_GEN_RF = 6;
	localparam int B_SEC_RF = 5;
	localparam int B_CRYPTO = 4;
	localparam int B_TADC_APB = 3;
	localparam int B_TADC_CORE = 2;
	localparam int B_SPI = 1;
	localparam int B_SCARD = 0;

	// Register bus request from software
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} bus_req_t;

	// All state of the block
	typedef struct packed {
		logic [REQ_W-1:0] req_a;
		logic [REQ_W-1:0] req_b;
		logic [31:0] rdata;
	} state_t;

endpackage

//--- verif/soft_reset_request_regs_tb.sv
// Testbench: masked soft reset request registers
`timescale 1ns/1ps
`default_nettype none

module soft_reset_request_regs_tb;
	import soft_reset_pkg::*;
	logic ref_clk_in = 1'b0;
	logic reset_n_in = 1'b0;
	logic [ADDR_W-1:0] addr_in = 12'h000;
	logic [31:0] wdata_in = 32'h0;
	logic wr_in = 1'b0;
	logic rd_in = 1'b0;
	logic [31:0] rdata_out;
	wire [15:0] oa;
	wire [15:0] ob;
	logic [15:0] ea = 16'h0000;
	logic [15:0] eb = 16'h0000;
	int n_mismatch = 0;
	int tests_run = 0;
	int cycles = 0;

	// Reserved position of register A has no output
	assign oa[15] = 1'b0;

	// Request outputs gathered into register bit order
	soft_reset_request_regs u_soft_reset_request_regs (
		.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
		.addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
		.rd_in(rd_in), .rdata_out(rdata_out),
		.disp_apb_reset_request_out(oa[14]),
		.disp_axi_reset_request_out(oa[13]),
		.ts_hsadc_reset_request_out(oa[12]),
		.ts_core_reset_request_out(oa[11]),
		.ts_ahb_reset_request_out(oa[10]),
		.ts_axi_reset_request_out(oa[9]),
		.dma_reset_request_out(oa[8]),
		.pwm_apb_reset_request_out(oa[7]),
		.pwm_core_reset_request_out(oa[6]),
		.fuse_nonsecure_apb_reset_request_out(oa[5]),
		.fuse_secure_apb_reset_request_out(oa[4]),
		.i2c_apb_reset_request_out(oa[3:0]),
		.usb3_regfile_reset_request_out(ob[15]),
		.timer_reset_request_out(ob[14:9]),
		.timer_block_apb_reset_request_out(ob[8]),
		.usb_regfile_reset_request_out(ob[7]),
		.gen_regfile_reset_request_out(ob[6]),
		.sec_regfile_reset_request_out(ob[5]),
		.crypto_reset_request_out(ob[4]),
		.tadc_apb_reset_request_out(ob[3]),
		.tadc_core_reset_request_out(ob[2]),
		.spi_first_reset_request_out(ob[1]),
		.smart_card_reset_request_out(ob[0])
	);

	// Clock, 50 ns period
	initial begin
		forever #25 ref_clk_in = ~ref_clk_in;
	end

	// Hang guard, far above the few hundred cycles needed
	always @(posedge ref_clk_in) begin
		cycles++;
		if (cycles == 5000) begin
			n_mismatch++;
			end_of_test();
		end
	end

	////////////////////////////////////////////////////////////////
	task automatic end_of_test();
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// One bus cycle; the next call drops the strobes
	task automatic bus(input logic w, input logic r, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge ref_clk_in);
		wr_in <= w;
		rd_in <= r;
		addr_in <= a;
		wdata_in <= d;
	endtask

	task automatic chk_out();
		check("outputs a", {16'h0000, ea}, {17'h00000, oa[14:0]});
		check("outputs b", {16'h0000, eb}, {16'h0000, ob});
	endtask

	// Masked write; reserved A15 never follows the data
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		if (a == 12'h30C)
			ea = ((ea & ~d[31:16]) | (d[15:0] & d[31:16])) & 16'h7FFF;
		if (a == 12'h310) eb = (eb & ~d[31:16]) | (d[15:0] & d[31:16]);
		bus(1'b1, 1'b0, a, d);
		bus(1'b0, 1'b0, a, 32'h0);
		#1;
		chk_out();
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		bus(1'b0, 1'b1, a, 32'h0);
		bus(1'b0, 1'b0, a, 32'h0);
		#1;
		check("read data", exp, rdata_out);
	endtask

	////////////////////////////////////////////////////////////////
	// Walk one bit through each register, then release it
	task automatic t_walk();
		for (int i = 0; i < 16; i++) begin
			wr(12'h30C, 32'h00010001 << i);
			rd(12'h30C, {16'h0000, ea});
			wr(12'h30C, 32'h00010000 << i);
			wr(12'h310, 32'h00010001 << i);
			rd(12'h310, {16'h0000, eb});
			wr(12'h310, 32'h00010000 << i);
		end
	endtask

	// Partial masks, back-to-back write and read, long hold
	task automatic t_mask();
		wr(12'h30C, 32'h0000FFFF);
		wr(12'h30C, 32'hFFFFFFFF);
		wr(12'h30C, 32'h0F00F0FF);
		bus(1'b1, 1'b0, 12'h310, 32'hFFFF5A5A);
		bus(1'b0, 1'b1, 12'h310, 32'h0);
		bus(1'b0, 1'b0, 12'h310, 32'h0);
		#1;
		check("read b", 32'h00005A5A, rdata_out);
		eb = 16'h5A5A;
		bus(1'b0, 1'b0, 12'h310, 32'h0);
		#1;
		check("read idle", 32'h0, rdata_out);
		repeat (20) @(posedge ref_clk_in);
		#1;
		chk_out();
		wr(12'h314, 32'hFFFFFFFF);
		rd(12'h314, 32'h0);
		rd(12'h30C, {16'h0000, ea});
	endtask

	// Reset in mid-run clears every request
	task automatic t_midreset();
		@(posedge ref_clk_in);
		reset_n_in <= 1'b0;
		@(posedge ref_clk_in);
		reset_n_in <= 1'b1;
		ea = 16'h0000;
		eb = 16'h0000;
		#1;
		chk_out();
		rd(12'h310, 32'h0);
	endtask

	initial begin
		repeat (3) @(posedge ref_clk_in);
		reset_n_in <= 1'b1;
		rd(12'h30C, 32'h0);
		chk_out();
		t_walk();
		t_mask();
		t_midreset();
		end_of_test();
	end
endmodule

`default_nettype wire
